/* core/pomc_pkg.sv */
//
// Purpose: Shared constants and types for the output macrocell block
// Assumes: Eight macrocells, eight product terms per cell
// Notes: Fuse words start at the fuse window base
//
package pomc_pkg;

	localparam int unsigned NUM_CELLS      = 8;
	localparam int unsigned TERMS_PER_CELL = 8;
	localparam int unsigned NUM_TERMS      = 64;

	typedef logic [7:0]  pomc_cells_t;
	typedef logic [10:0] pomc_ded_t;
	typedef logic [18:0] pomc_arr_t;
	typedef logic [21:0] pomc_pins_t;
	typedef logic [63:0] pomc_terms_t;
	typedef logic [5:0]  pomc_tidx_t;

	// Filtered pin vector layout
	localparam int unsigned PIN_DED_LSB = 0;
	localparam int unsigned PIN_CLK     = 11;
	localparam int unsigned PIN_OE      = 12;
	localparam int unsigned PIN_PD      = 13;
	localparam int unsigned PIN_PAD_LSB = 14;

	// Register byte addresses
	localparam logic [9:0] ADR_CTRL    = 10'h000;
	localparam logic [9:0] ADR_POL     = 10'h004;
	localparam logic [9:0] ADR_CELLIO  = 10'h008;
	localparam logic [9:0] ADR_PRELOAD = 10'h00C;
	localparam logic [9:0] ADR_STATUS  = 10'h010;
	localparam int unsigned FUSE_SEL_BIT = 9;

	// Field positions
	localparam int unsigned CTRL_SYNC_BIT = 0;
	localparam int unsigned CTRL_ARCH_BIT = 1;
	localparam int unsigned STAT_PD_BIT   = 2;
	localparam int unsigned STAT_PAD_LSB  = 8;

	// Reset values
	localparam logic [1:0]  CTRL_RST   = 2'h0;
	localparam pomc_cells_t POL_RST    = 8'h00;
	localparam pomc_cells_t CELLIO_RST = 8'h00;
	localparam pomc_arr_t   FUSE_RST   = 19'h7FFFF;

	// Cell positions
	localparam int unsigned OUTER_LO = 0;
	localparam int unsigned OUTER_HI = 7;
	localparam int unsigned INNER_LO = 3;
	localparam int unsigned INNER_HI = 4;
	localparam pomc_cells_t INNER_MASK = 8'h18;

	typedef enum logic [1:0] {
		MODE_OFF     = 2'b00,
		MODE_SIMPLE  = 2'b01,
		MODE_COMPLEX = 2'b10,
		MODE_REG     = 2'b11
	} pomc_mode_e;

	function automatic pomc_cells_t applyPol(input pomc_cells_t pol, input pomc_cells_t s);
		return s ^ ~pol;
	endfunction

endpackage

/* core/pomc_pin_filter.sv */
//
// Purpose: Three-flop pin synchroniser with agreement filter
// Assumes: Pins are asynchronous to clock
// Notes: Value moves only when the last two stages agree
//
`timescale 1ns/10ps
`default_nettype none

module pomc_pin_filter (
	input  wire logic                clock,
	input  wire logic                rstn,
	input  wire pomc_pkg::pomc_pins_t pinRaw,
	output var  pomc_pkg::pomc_pins_t pinValue
);

	pomc_pkg::pomc_pins_t stage1_q;
	pomc_pkg::pomc_pins_t stage2_q;
	pomc_pkg::pomc_pins_t stage3_q;

	always_ff @(posedge clock) begin
		if (!rstn) begin
			stage1_q <= '0;
			stage2_q <= '0;
			stage3_q <= '0;
		end else begin
			stage1_q <= pinRaw;
			stage2_q <= stage1_q;
			stage3_q <= stage2_q;
		end
	end

	// Agreeing bits follow, others hold
	always_ff @(posedge clock) begin
		if (!rstn) begin
			pinValue <= '0;
		end else begin
			pinValue <= (stage2_q & stage3_q) | (pinValue & (stage2_q ^ stage3_q));
		end
	end

endmodule

`default_nettype wire

/* core/pomc_term_array.sv */
//
// Purpose: Product-term fuse store and AND-array evaluation
// Assumes: One true and one complement mask per term
// Notes: Reset leaves every term erased, which evaluates false
//
`timescale 1ns/10ps
`default_nettype none

module pomc_term_array (
	input  wire logic                 clock,
	input  wire logic                 rstn,
	input  wire logic                 wrEn,
	input  wire pomc_pkg::pomc_tidx_t wrTerm,
	input  wire logic                 wrHalf,
	input  wire pomc_pkg::pomc_arr_t  wrData,
	input  wire pomc_pkg::pomc_arr_t  arrayIn,
	output var  pomc_pkg::pomc_arr_t  rdData,
	output var  pomc_pkg::pomc_terms_t terms
);

	pomc_pkg::pomc_arr_t trueMask [pomc_pkg::NUM_TERMS];
	pomc_pkg::pomc_arr_t compMask [pomc_pkg::NUM_TERMS];

	always_ff @(posedge clock) begin
		if (!rstn) begin
			for (int k = 0; k < pomc_pkg::NUM_TERMS; k++) begin
				trueMask[k] <= pomc_pkg::FUSE_RST;
				compMask[k] <= pomc_pkg::FUSE_RST;
			end
		end else if (wrEn) begin
			if (wrHalf) begin
				compMask[wrTerm] <= wrData;
			end else begin
				trueMask[wrTerm] <= wrData;
			end
		end
	end

	always_comb begin
		rdData = wrHalf ? compMask[wrTerm] : trueMask[wrTerm];
	end

	// Each term ANDs the selected true and complement columns
	always_comb begin
		for (int k = 0; k < pomc_pkg::NUM_TERMS; k++) begin
			terms[k] = &((~trueMask[k] | arrayIn) & (~compMask[k] | ~arrayIn));
		end
	end

endmodule

`default_nettype wire

/* core/pomc_core.sv */
//
// Purpose: Eight output macrocells with mode, polarity and feedback routing
// Assumes: Wishbone classic register access, pins pass a three-flop filter
// Notes: Standby freezes sampled inputs and outputs; cell registers take no clock but still accept preload
//
// Overview of operation
// - Two global bits choose one mode shared by all macrocells.
// - Per-cell polarity bit: zero active low, one active high.
// - Per-cell input/output bit; two global plus sixteen cell bits.
// - Sync bit zero with architecture bit one selects registered mode.
// - Registered mode: cell bit zero registered, one combinatorial I/O.
// - Registered mode: first input is clock, thirteenth is output enable.
// - Registered cells share one clock and one output enable.
// - Registered mode: any cell may be register or I/O.
// - Registered output uses eight terms, I/O cell seven.
// - Both bits one selects complex mode; cell bit ignored.
// - Complex mode: outer two cells are output only.
// - Complex mode: seven logic terms plus one enable term.
// - Complex mode: first and thirteenth inputs use outer feedback paths.
// - Simple mode: feedback via adjacent pins; inner cells always outputs.
// - Nineteen signals feed the AND array.
// - Cell registers clear on reset and can be preloaded.
// - Standby holds inputs and outputs.
// - Sync bit one, architecture bit zero selects simple mode.
// - Simple mode: cell bit one input, zero combinatorial output.
// - Simple outputs use eight terms with programmable polarity.
//
// The Wishbone slave port and the register addresses are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none

module pomc_core (
	input  wire logic                  clock,
	input  wire logic                  rstn,
	input  wire logic                  wb_cyc_i,
	input  wire logic                  wb_stb_i,
	input  wire logic                  wb_we_i,
	input  wire logic [9:0]            wb_adr_i,
	input  wire logic [3:0]            wb_sel_i,
	input  wire logic [31:0]           wb_dat_i,
	output var  logic [31:0]           wb_dat_o,
	output var  logic                  wb_ack_o,
	input  wire pomc_pkg::pomc_ded_t   dataPin,
	input  wire logic                  clkInPin,
	input  wire logic                  oeInPinN,
	input  wire logic                  powerDownPin,
	input  wire pomc_pkg::pomc_cells_t padIn,
	output var  pomc_pkg::pomc_cells_t padOut_q,
	output var  pomc_pkg::pomc_cells_t padOe_q
);

	logic [1:0]            ctrl_q;
	pomc_pkg::pomc_cells_t polarity_q;
	pomc_pkg::pomc_cells_t cellIo_q;
	pomc_pkg::pomc_cells_t cellReg_q;
	pomc_pkg::pomc_cells_t cellReg_d;
	pomc_pkg::pomc_pins_t  pinValue;
	pomc_pkg::pomc_pins_t  pinHeld_q;
	logic                  clkPrev_q;
	logic                  clkRise;
	logic                  powerDown;
	logic                  oeHeldN;
	logic                  clkHeld;
	pomc_pkg::pomc_cells_t padHeld;
	pomc_pkg::pomc_mode_e  mode;
	pomc_pkg::pomc_cells_t fbPath;
	pomc_pkg::pomc_arr_t   arrayIn;
	pomc_pkg::pomc_terms_t terms;
	pomc_pkg::pomc_arr_t   fuseRd;
	pomc_pkg::pomc_arr_t   fuseWrData;
	pomc_pkg::pomc_cells_t sum8;
	pomc_pkg::pomc_cells_t sum7;
	pomc_pkg::pomc_cells_t oeTerm;
	pomc_pkg::pomc_cells_t pol8;
	pomc_pkg::pomc_cells_t pol7;
	pomc_pkg::pomc_cells_t padOut_d;
	pomc_pkg::pomc_cells_t padOe_d;
	logic                  busReq;
	logic                  busWr;
	logic                  fuseSel;
	logic                  regWr;
	logic                  preloadWr;
	logic [31:0]           rdData_d;

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rstn);

	// Pin filtering and standby latch
	pomc_pin_filter u_filter (
		.clock    (clock),
		.rstn     (rstn),
		.pinRaw   ({padIn, powerDownPin, oeInPinN, clkInPin, dataPin}),
		.pinValue (pinValue)
	);

	assign powerDown = pinValue[pomc_pkg::PIN_PD];

	always_ff @(posedge clock) begin
		if (!rstn) begin
			pinHeld_q <= '0;
		end else if (!powerDown) begin
			pinHeld_q <= pinValue;
		end
	end

	assign oeHeldN = pinHeld_q[pomc_pkg::PIN_OE];
	assign clkHeld = pinHeld_q[pomc_pkg::PIN_CLK];
	assign padHeld = pinHeld_q[pomc_pkg::PIN_PAD_LSB +: pomc_pkg::NUM_CELLS];

	// Mode decode from the two global bits
	always_comb begin
		case ({ctrl_q[pomc_pkg::CTRL_SYNC_BIT], ctrl_q[pomc_pkg::CTRL_ARCH_BIT]})
			2'b01: mode = pomc_pkg::MODE_REG;
			2'b11: mode = pomc_pkg::MODE_COMPLEX;
			2'b10: mode = pomc_pkg::MODE_SIMPLE;
			default: mode = pomc_pkg::MODE_OFF;
		endcase
	end

	// Feedback routing per mode
	always_comb begin
		fbPath = '0;
		case (mode)
			pomc_pkg::MODE_REG: begin
				fbPath = (cellIo_q & padHeld) | (~cellIo_q & cellReg_q);
			end
			pomc_pkg::MODE_COMPLEX: begin
				fbPath = padHeld;
				fbPath[pomc_pkg::OUTER_LO] = oeHeldN;
				fbPath[pomc_pkg::OUTER_HI] = clkHeld;
			end
			pomc_pkg::MODE_SIMPLE: begin
				fbPath = {clkHeld, padHeld[7:5], padHeld[2:0], oeHeldN};
			end
			default: begin
				fbPath = '0;
			end
		endcase
	end

	// Dedicated inputs plus feedback, power-down pin excluded
	assign arrayIn = {fbPath, pinHeld_q[pomc_pkg::PIN_DED_LSB +: 11]};

	pomc_term_array u_terms (
		.clock   (clock),
		.rstn    (rstn),
		.wrEn    (busWr & fuseSel),
		.wrTerm  (wb_adr_i[8:3]),
		.wrHalf  (wb_adr_i[2]),
		.wrData  (fuseWrData),
		.arrayIn (arrayIn),
		.rdData  (fuseRd),
		.terms   (terms)
	);

	// Per-cell term sums
	always_comb begin
		for (int i = 0; i < pomc_pkg::NUM_CELLS; i++) begin
			sum8[i] = |terms[i * pomc_pkg::TERMS_PER_CELL +: 8];
			sum7[i] = |terms[i * pomc_pkg::TERMS_PER_CELL + 1 +: 7];
			oeTerm[i] = terms[i * pomc_pkg::TERMS_PER_CELL];
		end
	end

	assign pol8 = pomc_pkg::applyPol(polarity_q, sum8);
	assign pol7 = pomc_pkg::applyPol(polarity_q, sum7);
	assign cellReg_d = pol8;

	// Common clock edge and cell registers
	assign clkRise = pinValue[pomc_pkg::PIN_CLK] & ~clkPrev_q;

	always_ff @(posedge clock) begin
		if (!rstn) begin
			clkPrev_q <= 1'b0;
		end else begin
			clkPrev_q <= pinValue[pomc_pkg::PIN_CLK];
		end
	end

	always_ff @(posedge clock) begin
		if (!rstn) begin
			cellReg_q <= '0;
		end else if (preloadWr) begin
			cellReg_q <= wb_dat_i[7:0];
		end else if (mode == pomc_pkg::MODE_REG && clkRise && !powerDown) begin
			cellReg_q <= cellReg_d;
		end
	end

	// Pad drive per mode
	always_comb begin
		padOut_d = '0;
		padOe_d = '0;
		case (mode)
			pomc_pkg::MODE_REG: begin
				padOut_d = (~cellIo_q & cellReg_q) | (cellIo_q & pol7);
				padOe_d = (~cellIo_q & {8{~oeHeldN}}) | (cellIo_q & oeTerm);
			end
			pomc_pkg::MODE_COMPLEX: begin
				padOut_d = pol7;
				padOe_d = oeTerm;
			end
			pomc_pkg::MODE_SIMPLE: begin
				padOut_d = pol8;
				padOe_d = ~cellIo_q;
				padOe_d[pomc_pkg::INNER_LO] = 1'b1;
				padOe_d[pomc_pkg::INNER_HI] = 1'b1;
			end
			default: begin
				padOut_d = '0;
				padOe_d = '0;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (!rstn) begin
			padOut_q <= '0;
			padOe_q <= '0;
		end else if (!powerDown) begin
			padOut_q <= padOut_d;
			padOe_q <= padOe_d;
		end
	end

	// Wishbone slave
	assign busReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign busWr = busReq & wb_we_i;
	assign fuseSel = wb_adr_i[pomc_pkg::FUSE_SEL_BIT];
	assign regWr = busWr & ~fuseSel & wb_sel_i[0];
	assign preloadWr = regWr & (wb_adr_i == pomc_pkg::ADR_PRELOAD);

	assign fuseWrData = {
		wb_sel_i[2] ? wb_dat_i[18:16] : fuseRd[18:16],
		wb_sel_i[1] ? wb_dat_i[15:8] : fuseRd[15:8],
		wb_sel_i[0] ? wb_dat_i[7:0] : fuseRd[7:0]
	};

	always_ff @(posedge clock) begin
		if (!rstn) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= busReq;
		end
	end

	always_ff @(posedge clock) begin
		if (!rstn) begin
			ctrl_q <= pomc_pkg::CTRL_RST;
			polarity_q <= pomc_pkg::POL_RST;
			cellIo_q <= pomc_pkg::CELLIO_RST;
		end else if (regWr) begin
			if (wb_adr_i == pomc_pkg::ADR_CTRL) begin
				ctrl_q <= wb_dat_i[1:0];
			end else if (wb_adr_i == pomc_pkg::ADR_POL) begin
				polarity_q <= wb_dat_i[7:0];
			end else if (wb_adr_i == pomc_pkg::ADR_CELLIO) begin
				cellIo_q <= wb_dat_i[7:0];
			end
		end
	end

	always_comb begin
		rdData_d = '0;
		if (fuseSel) begin
			rdData_d[18:0] = fuseRd;
		end else if (wb_adr_i == pomc_pkg::ADR_CTRL) begin
			rdData_d[1:0] = ctrl_q;
		end else if (wb_adr_i == pomc_pkg::ADR_POL) begin
			rdData_d[7:0] = polarity_q;
		end else if (wb_adr_i == pomc_pkg::ADR_CELLIO) begin
			rdData_d[7:0] = cellIo_q;
		end else if (wb_adr_i == pomc_pkg::ADR_PRELOAD) begin
			rdData_d[7:0] = cellReg_q;
		end else if (wb_adr_i == pomc_pkg::ADR_STATUS) begin
			rdData_d[1:0] = mode;
			rdData_d[pomc_pkg::STAT_PD_BIT] = powerDown;
			rdData_d[pomc_pkg::STAT_PAD_LSB +: 8] = padHeld;
		end
	end

	always_ff @(posedge clock) begin
		if (!rstn) begin
			wb_dat_o <= '0;
		end else if (busReq) begin
			wb_dat_o <= rdData_d;
		end
	end

	// Checks
	a_reg_common_oe: assert property (
		(mode == pomc_pkg::MODE_REG && oeHeldN && !powerDown)
		|=> (padOe_q & ~$past(cellIo_q)) == 8'h00
	) else $error("registered cell driven while common enable off");

	a_reg_capture: assert property (
		(mode == pomc_pkg::MODE_REG && clkRise && !powerDown && !preloadWr)
		|=> cellReg_q == $past(cellReg_d)
	) else $error("cell register missed clock rise");

	a_reg_no_edge: assert property (
		(!clkRise && !preloadWr) |=> $stable(cellReg_q)
	) else $error("cell register changed without clock rise");

	a_preload_load: assert property (
		preloadWr |=> cellReg_q == $past(wb_dat_i[7:0])
	) else $error("preload value not loaded");

	a_complex_outer_fb: assert property (
		(mode == pomc_pkg::MODE_COMPLEX)
		|-> (arrayIn[11 + pomc_pkg::OUTER_LO] == pinHeld_q[pomc_pkg::PIN_OE]
			&& arrayIn[11 + pomc_pkg::OUTER_HI] == pinHeld_q[pomc_pkg::PIN_CLK])
	) else $error("outer feedback not carrying dedicated inputs");

	a_complex_oe_term: assert property (
		(mode == pomc_pkg::MODE_COMPLEX && !powerDown) |=> padOe_q == $past(oeTerm)
	) else $error("complex enable not from enable term");

	a_simple_inner_out: assert property (
		(mode == pomc_pkg::MODE_SIMPLE && !powerDown)
		|=> (padOe_q & pomc_pkg::INNER_MASK) == pomc_pkg::INNER_MASK
	) else $error("inner cell not driving in simple mode");

	a_simple_ded_input: assert property (
		(mode == pomc_pkg::MODE_SIMPLE && !powerDown)
		|=> (padOe_q & $past(cellIo_q) & ~pomc_pkg::INNER_MASK) == 8'h00
	) else $error("input cell driving in simple mode");

	a_polarity_simple: assert property (
		(mode == pomc_pkg::MODE_SIMPLE && !powerDown)
		|=> padOut_q == ($past(sum8) ^ ~$past(polarity_q))
	) else $error("simple output polarity wrong");

	a_standby_hold: assert property (
		(powerDown && $past(powerDown))
		|-> ($stable(padOut_q) && $stable(padOe_q) && $stable(pinHeld_q))
	) else $error("state moved during standby");

	a_wb_ack_pulse: assert property (
		busReq |=> wb_ack_o ##1 !wb_ack_o
	) else $error("ack not a single cycle after request");

endmodule

`default_nettype wire

/* verification/pomc_board.sv */
//
// Purpose: Board logic around the macrocells: pin drivers and pad wires
// Assumes: Board drives a pad only while the cell releases it
// Notes: Pad wire resolved from the cell enable
//
`timescale 1ns/10ps
`default_nettype none

module pomc_board (
	input  wire logic                  clkSet,
	input  wire logic                  oeSetN,
	input  wire logic                  pdSet,
	input  wire pomc_pkg::pomc_ded_t   dedSet,
	input  wire pomc_pkg::pomc_cells_t extPad,
	input  wire pomc_pkg::pomc_cells_t padOut,
	input  wire pomc_pkg::pomc_cells_t padOe,
	output var  pomc_pkg::pomc_ded_t   dataPin,
	output var  logic                  clkInPin,
	output var  logic                  oeInPinN,
	output var  logic                  powerDownPin,
	output var  pomc_pkg::pomc_cells_t padIn
);
	// Standby request kept on its own pin only
	always_comb begin
		dataPin      = dedSet;
		clkInPin     = clkSet;
		oeInPinN     = oeSetN;
		powerDownPin = pdSet;
		padIn        = (padOe & padOut) | (~padOe & extPad);
	end
endmodule

`default_nettype wire

/* verification/tb_top.sv */
//
// Purpose: Bus and pin sequences for the macrocell block
// Assumes: Ack one cycle after a taken request, pins seen six edges later
// Notes: Terms built from fuse masks
//
`timescale 1ns/10ps
`default_nettype none

module tb_top;
	logic                  clock = 1'b0;
	logic                  rstn = 1'b0;
	logic                  cyc = 1'b0;
	logic                  stb = 1'b0;
	logic                  we = 1'b0;
	logic [9:0]            adr = 10'h000;
	logic [3:0]            sel = 4'h0;
	logic [31:0]           wdat = 32'h00000000;
	logic [31:0]           rdat;
	logic                  ack;
	logic [31:0]           rd;
	logic                  clkSet = 1'b0;
	logic                  oeSetN = 1'b0;
	logic                  pdSet = 1'b0;
	pomc_pkg::pomc_ded_t   dedSet = 11'h000;
	pomc_pkg::pomc_cells_t extPad = 8'h00;
	pomc_pkg::pomc_ded_t   dataPin;
	logic                  clkInPin;
	logic                  oeInPinN;
	logic                  powerDownPin;
	pomc_pkg::pomc_cells_t padIn;
	pomc_pkg::pomc_cells_t padOut;
	pomc_pkg::pomc_cells_t padOe;
	logic [1:0]            modeTab [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
	int                    err_count = 0;
	int                    tests_run = 0;

	always #25 clock = ~clock;

	pomc_core i_pomc_core (.clock(clock), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .dataPin(dataPin), .clkInPin(clkInPin), .oeInPinN(oeInPinN),
		.powerDownPin(powerDownPin), .padIn(padIn), .padOut_q(padOut), .padOe_q(padOe));

	pomc_board i_pomc_board (.clkSet(clkSet), .oeSetN(oeSetN), .pdSet(pdSet),
		.dedSet(dedSet), .extPad(extPad), .padOut(padOut), .padOe(padOe),
		.dataPin(dataPin), .clkInPin(clkInPin), .oeInPinN(oeInPinN),
		.powerDownPin(powerDownPin), .padIn(padIn));

	task automatic end_sim();
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
		end
	endtask

	task automatic waitc(input int n);
		repeat (n) @(posedge clock);
		@(negedge clock);
	endtask

	task automatic wb(input logic w, input logic [9:0] a, input logic [31:0] d,
		input logic [3:0] s);
		int k;
		@(posedge clock);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= s;
		k = 0;
		do begin
			@(posedge clock);
			k++;
		end while (ack !== 1'b1 && k < 20);
		rd = rdat;
		if (ack !== 1'b1) begin
			err_count++;
			end_sim();
		end
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(posedge clock);
	endtask

	task automatic wr(input logic [9:0] a, input logic [31:0] d);
		wb(1'b1, a, d, 4'hF);
	endtask

	task automatic fuse(input int t, input logic [18:0] tru, input logic [18:0] cmp);
		wr(10'h200 + 10'(8 * t), {13'h0000, tru});
		wr(10'h204 + 10'(8 * t), {13'h0000, cmp});
	endtask

	task automatic pins(input logic c, input logic o, input logic p, input logic d0);
		@(posedge clock);
		clkSet <= c;
		oeSetN <= o;
		pdSet <= p;
		dedSet <= {10'h000, d0};
	endtask

	initial begin
		repeat (8) @(posedge clock);
		rstn <= 1'b1;
		waitc(1);
		chk(32'(padOut), 32'h0);
		chk(32'(padOe), 32'h0);
		wb(1'b0, 10'h014, 32'h0, 4'hF);
		chk(rd, 32'h0);
		wb(1'b1, pomc_pkg::ADR_POL, 32'h0F, 4'h0);
		wb(1'b0, pomc_pkg::ADR_POL, 32'h0, 4'hF);
		chk(rd, 32'h0);
		for (int m = 0; m < 4; m++) begin
			wr(pomc_pkg::ADR_CTRL, 32'(m));
			wb(1'b0, pomc_pkg::ADR_STATUS, 32'h0, 4'hF);
			chk(32'(rd[1:0]), 32'(modeTab[m]));
		end
		// Simple mode, inner cells stay outputs
		wr(pomc_pkg::ADR_POL, 32'h0F);
		wr(pomc_pkg::ADR_CELLIO, 32'hFF);
		wr(pomc_pkg::ADR_CTRL, 32'h1);
		waitc(6);
		chk(32'(padOe), 32'h18);
		chk(32'(padOut & padOe), 32'h10);
		// Input cells take board levels
		@(posedge clock);
		extPad <= 8'hA5;
		waitc(6);
		wb(1'b0, pomc_pkg::ADR_STATUS, 32'h0, 4'hF);
		extPad <= 8'h00;
		chk(32'(rd[15:8]), 32'hB5);
		wr(pomc_pkg::ADR_CELLIO, 32'h00);
		fuse(16, 19'h00001, 19'h00000);
		fuse(8, 19'h04000, 19'h00000);
		waitc(6);
		chk(32'(padOe), 32'hFF);
		chk(32'(padOut), 32'hF0);
		pins(1'b0, 1'b0, 1'b0, 1'b1);
		waitc(12);
		chk(32'(padOut), 32'hF6);
		// Standby freezes inputs and outputs
		pins(1'b0, 1'b0, 1'b1, 1'b1);
		waitc(6);
		wb(1'b0, pomc_pkg::ADR_STATUS, 32'h0, 4'hF);
		chk(32'(rd[2]), 32'h1);
		pins(1'b0, 1'b0, 1'b1, 1'b0);
		waitc(12);
		chk(32'(padOut), 32'hF6);
		pins(1'b0, 1'b0, 1'b0, 1'b0);
		waitc(12);
		chk(32'(padOut), 32'hF0);
		// Registered mode, cell 2 registered
		wr(pomc_pkg::ADR_CELLIO, 32'hFB);
		wr(pomc_pkg::ADR_CTRL, 32'h2);
		pins(1'b0, 1'b0, 1'b0, 1'b1);
		waitc(6);
		chk(32'(padOe), 32'h04);
		chk(32'(padOut[2]), 32'h0);
		pins(1'b1, 1'b0, 1'b0, 1'b1);
		waitc(6);
		chk(32'(padOut[2]), 32'h1);
		pins(1'b0, 1'b1, 1'b0, 1'b1);
		waitc(6);
		chk(32'(padOe[2]), 32'h0);
		pins(1'b0, 1'b0, 1'b0, 1'b1);
		wr(pomc_pkg::ADR_PRELOAD, 32'h5A);
		wb(1'b0, pomc_pkg::ADR_PRELOAD, 32'h0, 4'hF);
		chk(32'(rd[7:0]), 32'h5A);
		waitc(6);
		chk(32'(padOut[2]), 32'h0);
		// Complex mode, enable terms and clock input on outer feedback path
		pins(1'b0, 1'b0, 1'b0, 1'b0);
		fuse(40, 19'h00000, 19'h00000);
		fuse(24, 19'h00000, 19'h00000);
		fuse(25, 19'h40000, 19'h00000);
		wr(pomc_pkg::ADR_CTRL, 32'h3);
		waitc(8);
		chk(32'(padOe), 32'h28);
		chk(32'(padOut[3]), 32'h0);
		wr(pomc_pkg::ADR_CELLIO, 32'h00);
		pins(1'b1, 1'b0, 1'b0, 1'b0);
		waitc(14);
		chk(32'(padOut[3]), 32'h1);
		chk(32'(padOe), 32'h2A);
		end_sim();
	end
endmodule

`default_nettype wire
